// ### logic/cmc_map.vh
// Register offsets, field positions, reset values and counts for the CAN mode controller.
// Included by the controller top; holds definitions only.
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// Byte addresses, one aligned 32-bit word each, except CMC_OFF_TOP, the last byte of the map
`define CMC_OFF_SRR 10'h000
`define CMC_OFF_MSR 10'h004
`define CMC_OFF_PRESCALER_REG 10'h008
`define CMC_OFF_BTR 10'h00c
`define CMC_OFF_ECR 10'h010
`define CMC_OFF_ESR 10'h014
`define CMC_OFF_SR 10'h018
`define CMC_OFF_ISR 10'h01c
`define CMC_OFF_IER 10'h020
`define CMC_OFF_ICR 10'h024
`define CMC_OFF_TXF_ID 10'h030
`define CMC_OFF_TXF_D2 10'h03c
`define CMC_OFF_HPB_ID 10'h040
`define CMC_OFF_HPB_D2 10'h04c
`define CMC_OFF_RXF_ID 10'h050
`define CMC_OFF_RXF_D2 10'h05c
`define CMC_OFF_TOP 10'h0ff

// soft_reset_reg fields
`define CMC_SRR_RST 0
`define CMC_SRR_CEN 1
// mode_select_reg fields
`define CMC_MSR_SLEEP 0
`define CMC_MSR_LOOPBACK_SELECT 1
// bit_timing_reg fields
`define CMC_BTR_TS1_LSB 0
`define CMC_BTR_TS1_MSB 3
`define CMC_BTR_TS2_LSB 4
`define CMC_BTR_TS2_MSB 6
`define CMC_BTR_SJW_LSB 7
`define CMC_BTR_SJW_MSB 8
// mode_status_reg fields (bits 3:0 are the one-hot mode)
`define CMC_SR_HPB_FULL 10
`define CMC_SR_TXF_FULL 11

// interrupt_status_reg / interrupt_enable_reg bit positions
`define CMC_IS_ARBLOST 0
`define CMC_IS_TXDONE 1
`define CMC_IS_ERROR 2
`define CMC_IS_RXOVF 3
`define CMC_IS_RXUNF 4
`define CMC_IS_RXDONE 5
`define CMC_IS_HPBFULL 6
`define CMC_IS_TXFULL 7
`define CMC_IS_WAKE 8
`define CMC_IS_SLEEP 9
`define CMC_IS_BUSOFF 10
`define CMC_IS_RX_NOT_EMPTY_FLAG 11
`define CMC_IS_W 12
// Flags wiped on entry to configuration mode
`define CMC_IS_CFG_CLR 12'h72f

// Reset values
`define CMC_RST_PRESC 8'h00
`define CMC_RST_BTR 9'h000
`define CMC_RST_IER 12'h000

// Bus response codes
`define CMC_RESP_OKAY 2'h0
`define CMC_RESP_SLVERR 2'h2
`define CMC_RESP_DECERR 2'h3

// Counts
`define CMC_IDLE_BITS 4'hb
`define CMC_TX_DEPTH 2'h2
`define CMC_RX_DEPTH 2'h2
`define CMC_BIT_FIXED_TQ 5'h02

`endif

// ### logic/cmc_mode_ctrl.v
// CAN controller operating-mode sequencer with its register slave.
// Assumes an Avalon-MM master on the same clock and a frame engine on the
// same clock; bus_rx_in comes straight from a transceiver pin.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "cmc_map.vh"

module cmc_mode_ctrl (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Avalon-MM slave
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [1:0] avs_response,
    // Transceiver pins
    input wire bus_rx_in,
    output reg bus_tx_out,
    // Frame engine side
    input wire eng_tx_bit,
    output reg eng_rx_bit,
    output reg eng_bit_tick,
    output wire eng_tx_allowed,
    output wire eng_rx_allowed,
    output wire eng_loopback,
    output wire eng_tx_pending,
    output wire eng_tx_from_priority,
    input wire eng_tx_take,
    input wire eng_tx_done,
    input wire eng_rx_store,
    input wire eng_arb_lost,
    input wire eng_error,
    input wire [4:0] eng_error_kind,
    input wire eng_bus_off,
    input wire eng_bus_idle,
    input wire [7:0] eng_tec,
    input wire [7:0] eng_rec,
    // Interrupt
    output reg irq_out
);

    localparam ST_CONFIG = 4'b0001;
    localparam ST_LOOP = 4'b0010;
    localparam ST_SLEEP = 4'b0100;
    localparam ST_NORMAL = 4'b1000;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = wd[i*8 +: 8];
                end
            end
        end
    endfunction

    // Bus handshake: capture cycle, then one answer cycle
    reg ack_q;
    wire access = avs_read | avs_write;
    wire capture = access & ~ack_q;
    wire wr_commit = avs_write & ack_q;
    wire rd_commit = avs_read & ack_q;
    wire [9:0] addr = {avs_address[9:2], 2'b00};
    assign avs_waitrequest = capture;

    reg cen_q;
    reg sleep_sel_q;
    reg loop_sel_q;
    reg [7:0] presc_q;
    reg [8:0] btr_q;
    reg [15:0] ecr_q;
    reg [4:0] esr_q;
    reg [11:0] isr_q;
    reg [11:0] ier_q;
    reg [3:0] mode_q;
    reg [3:0] mode_d;
    reg [1:0] tx_cnt_q;
    reg hpb_full_q;
    reg [1:0] rx_cnt_q;
    reg rx_meta_q;
    reg rx_sync_q;
    reg rx_prev_q;
    reg [7:0] tq_cnt_q;
    reg [4:0] bit_cnt_q;
    reg [3:0] rcsv_cnt_q;
    reg [31:0] rd_data;
    reg [1:0] rd_resp;

    wire [31:0] wmerge = merge(32'h0000_0000, avs_writedata, avs_byteenable);
    wire soft_rst = wr_commit && addr == `CMC_OFF_SRR && wmerge[`CMC_SRR_RST];
    // Whole core, bus slave and pin synchroniser excepted, restarts on either reset
    wire rst_all = ~resetn | soft_rst;
    wire in_cfg = mode_q[0];
    wire running = mode_q[1] | mode_q[3];
    wire cfg_enter = ~in_cfg & mode_d[0];

    // Two-flop pin synchroniser; nothing reads rx_meta_q but rx_sync_q
    always @(posedge clock) begin
        if (!resetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= bus_rx_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end
    wire rx_fall = rx_prev_q & ~rx_sync_q;

    // Bit-rate enable from prescaler and segment lengths
    wire [4:0] bit_len = `CMC_BIT_FIXED_TQ + {1'b0, btr_q[`CMC_BTR_TS1_MSB:`CMC_BTR_TS1_LSB]}
        + {2'b00, btr_q[`CMC_BTR_TS2_MSB:`CMC_BTR_TS2_LSB]};
    wire tq_wrap = tq_cnt_q == presc_q;
    wire bit_tick = tq_wrap && bit_cnt_q == bit_len;
    always @(posedge clock) begin
        if (rst_all) begin
            tq_cnt_q <= 8'h00;
            bit_cnt_q <= 5'h00;
            eng_bit_tick <= 1'b0;
        end else begin
            eng_bit_tick <= bit_tick & ~in_cfg;
            if (tq_wrap) begin
                tq_cnt_q <= 8'h00;
                bit_cnt_q <= (bit_cnt_q == bit_len) ? 5'h00 : bit_cnt_q + 5'h01;
            end else begin
                tq_cnt_q <= tq_cnt_q + 8'h01;
            end
        end
    end

    // Recessive run length seen while waiting to leave configuration
    always @(posedge clock) begin
        if (rst_all || !cen_q || !in_cfg) begin
            rcsv_cnt_q <= 4'h0;
        end else if (bit_tick) begin
            if (!rx_sync_q) begin
                rcsv_cnt_q <= 4'h0;
            end else if (rcsv_cnt_q != `CMC_IDLE_BITS) begin
                rcsv_cnt_q <= rcsv_cnt_q + 4'h1;
            end
        end
    end

    // Frame store occupancy; frame contents live outside this block
    wire txf_wr = wr_commit && addr == `CMC_OFF_TXF_D2;
    wire hpb_wr = wr_commit && addr == `CMC_OFF_HPB_D2;
    wire txf_push = txf_wr && tx_cnt_q != `CMC_TX_DEPTH;
    wire hpb_push = hpb_wr && !hpb_full_q;
    wire tx_pending = hpb_full_q | (tx_cnt_q != 2'h0);
    wire tx_take = eng_tx_take & running & tx_pending;
    wire rx_pop_req = rd_commit && addr == `CMC_OFF_RXF_D2;
    wire rx_pop = rx_pop_req && rx_cnt_q != 2'h0;
    wire rx_in = eng_rx_store & running;
    wire rx_push = rx_in && rx_cnt_q != `CMC_RX_DEPTH;
    wire new_frame = txf_push | hpb_push;

    always @(posedge clock) begin
        if (rst_all) begin
            tx_cnt_q <= 2'h0;
            hpb_full_q <= 1'b0;
            rx_cnt_q <= 2'h0;
        end else begin
            // Pending frames survive configuration mode
            if (hpb_push) begin
                hpb_full_q <= 1'b1;
            end else if (tx_take && hpb_full_q) begin
                hpb_full_q <= 1'b0;
            end
            if (txf_push && !(tx_take && !hpb_full_q)) begin
                tx_cnt_q <= tx_cnt_q + 2'h1;
            end else if (!txf_push && tx_take && !hpb_full_q) begin
                tx_cnt_q <= tx_cnt_q - 2'h1;
            end
            if (rx_push && !rx_pop) begin
                rx_cnt_q <= rx_cnt_q + 2'h1;
            end else if (rx_pop && !rx_push) begin
                rx_cnt_q <= rx_cnt_q - 2'h1;
            end
        end
    end

    // Mode sequencer
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_CONFIG: begin
                if (cen_q && rcsv_cnt_q == `CMC_IDLE_BITS) begin
                    if (loop_sel_q) begin
                        mode_d = ST_LOOP;
                    end else if (sleep_sel_q && !tx_pending) begin
                        mode_d = ST_SLEEP;
                    end else begin
                        mode_d = ST_NORMAL;
                    end
                end
            end
            ST_NORMAL: begin
                if (!cen_q) begin
                    mode_d = ST_CONFIG;
                end else if (sleep_sel_q && eng_bus_idle && !tx_pending && !new_frame) begin
                    mode_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!cen_q) begin
                    mode_d = ST_CONFIG;
                end else if (!sleep_sel_q || rx_fall || new_frame || tx_pending) begin
                    mode_d = ST_NORMAL;
                end
            end
            ST_LOOP: begin
                if (!cen_q) begin
                    mode_d = ST_CONFIG;
                end
            end
            default: begin
                mode_d = ST_CONFIG;
            end
        endcase
        if (!cen_q) begin
            mode_d = ST_CONFIG;
        end
    end

    always @(posedge clock) begin
        if (rst_all) begin
            mode_q <= ST_CONFIG;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire sleep_enter = ~mode_q[2] & mode_d[2];
    wire wake = mode_q[2] & mode_d[3];

    // Line drive; loopback and idle modes hold the pin recessive
    always @(posedge clock) begin
        if (rst_all) begin
            bus_tx_out <= 1'b1;
            eng_rx_bit <= 1'b1;
        end else begin
            bus_tx_out <= mode_q[3] ? eng_tx_bit : 1'b1;
            if (mode_q[1]) begin
                eng_rx_bit <= eng_tx_bit;
            end else if (mode_q[3] || mode_q[2]) begin
                eng_rx_bit <= rx_sync_q;
            end else begin
                eng_rx_bit <= 1'b1;
            end
        end
    end

    assign eng_tx_allowed = running;
    assign eng_rx_allowed = mode_q[3] | mode_q[2];
    assign eng_loopback = mode_q[1];
    assign eng_tx_pending = tx_pending;
    assign eng_tx_from_priority = hpb_full_q;

    // Configuration registers; soft reset clears them and the reset bit
    wire srr_wr = wr_commit && addr == `CMC_OFF_SRR;
    wire msr_wr = wr_commit && addr == `CMC_OFF_MSR && in_cfg;
    wire timing_wr_ok = in_cfg & ~cen_q;
    wire [31:0] msr_m = merge({30'h0, loop_sel_q, sleep_sel_q}, avs_writedata, avs_byteenable);
    wire [31:0] srr_m = merge({30'h0, cen_q, 1'b0}, avs_writedata, avs_byteenable);
    wire [31:0] prescaler_reg_m = merge({24'h0, presc_q}, avs_writedata, avs_byteenable);
    wire [31:0] btr_m = merge({23'h0, btr_q}, avs_writedata, avs_byteenable);
    wire [31:0] ier_m = merge({20'h0, ier_q}, avs_writedata, avs_byteenable);
    always @(posedge clock) begin
        if (rst_all) begin
            cen_q <= 1'b0;
            sleep_sel_q <= 1'b0;
            loop_sel_q <= 1'b0;
            presc_q <= `CMC_RST_PRESC;
            btr_q <= `CMC_RST_BTR;
            ier_q <= `CMC_RST_IER;
        end else begin
            if (srr_wr) begin
                cen_q <= srr_m[`CMC_SRR_CEN];
            end
            if (msr_wr) begin
                sleep_sel_q <= msr_m[`CMC_MSR_SLEEP];
                loop_sel_q <= msr_m[`CMC_MSR_LOOPBACK_SELECT];
            end else if (wr_commit && addr == `CMC_OFF_MSR && mode_q[2] && !msr_m[`CMC_MSR_SLEEP]) begin
                sleep_sel_q <= 1'b0;
            end
            if (wr_commit && addr == `CMC_OFF_PRESCALER_REG && timing_wr_ok) begin
                presc_q <= prescaler_reg_m[7:0];
            end
            if (wr_commit && addr == `CMC_OFF_BTR && timing_wr_ok) begin
                btr_q <= btr_m[8:0];
            end
            if (wr_commit && addr == `CMC_OFF_IER) begin
                ier_q <= ier_m[11:0];
            end
        end
    end

    // Error counters mirror the engine outside configuration mode
    wire [4:0] esr_clr = (wr_commit && addr == `CMC_OFF_ESR) ? wmerge[4:0] : 5'h00;
    wire [4:0] esr_set = (eng_error & running) ? eng_error_kind : 5'h00;
    always @(posedge clock) begin
        if (rst_all || in_cfg) begin
            ecr_q <= 16'h0000;
            esr_q <= 5'h00;
        end else begin
            ecr_q <= {eng_rec, eng_tec};
            esr_q <= (esr_q & ~esr_clr) | esr_set;
        end
    end

    // Interrupt flags: a set in the same cycle as a clear wins
    reg [11:0] isr_set;
    always @* begin
        isr_set = 12'h000;
        isr_set[`CMC_IS_ARBLOST] = eng_arb_lost & running;
        isr_set[`CMC_IS_TXDONE] = eng_tx_done & running;
        isr_set[`CMC_IS_ERROR] = eng_error & running;
        isr_set[`CMC_IS_BUSOFF] = eng_bus_off & running;
        isr_set[`CMC_IS_RXOVF] = rx_in & ~rx_push;
        isr_set[`CMC_IS_RXDONE] = rx_push;
        isr_set[`CMC_IS_RX_NOT_EMPTY_FLAG] = rx_push;
        isr_set[`CMC_IS_RXUNF] = rx_pop_req & ~rx_pop;
        isr_set[`CMC_IS_HPBFULL] = hpb_push;
        isr_set[`CMC_IS_TXFULL] = txf_push && tx_cnt_q == `CMC_TX_DEPTH - 2'h1;
        isr_set[`CMC_IS_SLEEP] = sleep_enter;
        isr_set[`CMC_IS_WAKE] = wake;
    end
    wire [11:0] isr_clr = (wr_commit && addr == `CMC_OFF_ICR) ? wmerge[11:0] : 12'h000;
    wire [11:0] cfg_wipe = cfg_enter ? `CMC_IS_CFG_CLR : 12'h000;
    always @(posedge clock) begin
        if (rst_all) begin
            isr_q <= 12'h000;
            irq_out <= 1'b0;
        end else begin
            isr_q <= ((isr_q & ~isr_clr) | isr_set) & ~cfg_wipe;
            // Level rises whenever an enabled flag stands, in any mode
            irq_out <= |(isr_q & ier_q);
        end
    end

    // Read mux and answer codes
    always @* begin
        rd_data = 32'h0000_0000;
        rd_resp = `CMC_RESP_OKAY;
        if (addr > `CMC_OFF_TOP) begin
            rd_resp = `CMC_RESP_DECERR;
        end else begin
            case (addr)
                `CMC_OFF_SRR: rd_data = {30'h0, cen_q, 1'b0};
                `CMC_OFF_MSR: rd_data = {30'h0, loop_sel_q, sleep_sel_q};
                `CMC_OFF_PRESCALER_REG: rd_data = {24'h0, presc_q};
                `CMC_OFF_BTR: rd_data = {23'h0, btr_q};
                `CMC_OFF_ECR: rd_data = {16'h0, ecr_q};
                `CMC_OFF_ESR: rd_data = {27'h0, esr_q};
                `CMC_OFF_SR: rd_data = {20'h0, tx_cnt_q == `CMC_TX_DEPTH, hpb_full_q, 6'h00, mode_q};
                `CMC_OFF_ISR: rd_data = {20'h0, isr_q};
                `CMC_OFF_IER: rd_data = {20'h0, ier_q};
                default: rd_data = 32'h0000_0000;
            endcase
            if (avs_write) begin
                if ((addr == `CMC_OFF_PRESCALER_REG || addr == `CMC_OFF_BTR) && !timing_wr_ok) begin
                    rd_resp = `CMC_RESP_SLVERR;
                end else if (addr == `CMC_OFF_ECR || addr == `CMC_OFF_SR || addr == `CMC_OFF_ISR
                    || (addr >= `CMC_OFF_RXF_ID && addr <= `CMC_OFF_RXF_D2)) begin
                    rd_resp = `CMC_RESP_SLVERR;
                end
            end else if (addr == `CMC_OFF_ICR || (addr >= `CMC_OFF_TXF_ID && addr <= `CMC_OFF_HPB_D2)) begin
                rd_resp = `CMC_RESP_SLVERR;
            end
        end
    end

    // Bus slave keeps running through soft reset so the reset write completes
    always @(posedge clock) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_response <= `CMC_RESP_OKAY;
        end else begin
            ack_q <= capture;
            if (capture) begin
                avs_readdata <= avs_read ? rd_data : 32'h0000_0000;
                avs_response <= rd_resp;
            end
        end
    end

endmodule

// ### testbench/cmc_mode_ctrl_assertions.sv
// Checker for the CAN mode controller: mode outputs, pins and bus answers.
// Bound onto cmc_mode_ctrl; sees its ports only.
`timescale 1ns/100ps
module cmc_mode_ctrl_assertions (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Register bus
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [1:0] avs_response,
    // Pins, engine side, interrupt
    input wire bus_tx_out,
    input wire eng_tx_bit,
    input wire eng_rx_bit,
    input wire eng_bit_tick,
    input wire eng_tx_allowed,
    input wire eng_rx_allowed,
    input wire eng_loopback,
    input wire eng_tx_pending,
    input wire irq_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    wire cfg_m = !eng_tx_allowed && !eng_rx_allowed;
    wire slp_m = eng_rx_allowed && !eng_tx_allowed;
    wire nrm_m = eng_rx_allowed && eng_tx_allowed;
    sequence s_req_start;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_done;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    a_one_wait: assert property (s_req_start |=> !avs_waitrequest)
        else $error("bus answer late");
    a_resp_code: assert property (s_req_done |-> avs_response != 2'h1)
        else $error("illegal response code");
    a_dec_err: assert property (s_req_done ##0 (avs_address > 10'h0ff) |-> avs_response == 2'h3)
        else $error("no decode error above map");
    a_cfg_recessive: assert property (cfg_m [*2] |-> bus_tx_out && !eng_bit_tick)
        else $error("pin or tick active in configuration");
    a_loop_back: assert property (eng_loopback [*2] |-> bus_tx_out && eng_rx_bit == $past(eng_tx_bit))
        else $error("loopback path wrong");
    a_normal_drive: assert property (nrm_m [*2] |-> bus_tx_out == $past(eng_tx_bit))
        else $error("pin does not follow engine");
    a_sleep_entry: assert property ($rose(slp_m) |-> !$past(eng_tx_pending))
        else $error("sleep entered with frame pending");
    a_sleep_wake: assert property (slp_m && eng_tx_pending |-> ##[1:2] (nrm_m || cfg_m))
        else $error("pending frame did not wake");
    a_loop_exit: assert property ($fell(eng_loopback) |-> cfg_m)
        else $error("loopback left to other than configuration");
    a_mode_onehot: assert property (!(eng_loopback && eng_rx_allowed) && (!eng_loopback || eng_tx_allowed))
        else $error("mode outputs inconsistent");
    a_reset_state: assert property (disable iff (1'b0) !resetn |=> bus_tx_out && !irq_out && cfg_m)
        else $error("reset state wrong");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_assertions u_chk (.clock, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .avs_response, .bus_tx_out, .eng_tx_bit, .eng_rx_bit, .eng_bit_tick,
    .eng_tx_allowed, .eng_rx_allowed, .eng_loopback, .eng_tx_pending, .irq_out);

// ### testbench/cmc_phy_model.sv
// Transceiver plus bus: wired-AND of our transmit with other nodes.
// Assumes the bench asks for a dominant level from another node.
`timescale 1ns/100ps
module cmc_phy_model #(
    parameter int LAG_NS = 30
) (
    // Controller pins
    input wire txd,
    output logic rxd,
    // Another node on the bus
    input wire other_dom
);
    // Recessive pull-up, so a released bus reads 1
    initial rxd = 1'b1;
    always @(txd or other_dom) rxd <= #(LAG_NS) txd & ~other_dom;
endmodule

// ### testbench/test_cmc_mode_ctrl.sv
// Self-checking bench for the CAN mode controller.
// Assumes the design, its map header and the transceiver model compile first.
`timescale 1ns/100ps
`include "cmc_map.vh"
`define CHK(nm, ex, got) \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end
module test_cmc_mode_ctrl;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, bus_rx_in, bus_tx_out, irq_out;
    wire [1:0] avs_response;
    wire eng_rx_bit, eng_bit_tick, eng_tx_allowed, eng_rx_allowed, eng_loopback, eng_tx_pending;
    logic other_dom = 1'b0;
    logic eng_tx_bit = 1'b1;
    logic eng_tx_take = 1'b0;
    logic eng_tx_done = 1'b0;
    logic eng_rx_store = 1'b0;
    logic eng_bus_idle = 1'b0;
    logic [7:0] eng_tec = 8'h00;
    logic [7:0] eng_rec = 8'h00;
    logic [31:0] rd_q;
    logic [1:0] rs_q;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    wire [2:0] mode = {eng_tx_allowed, eng_rx_allowed, eng_loopback};
    cmc_mode_ctrl uut (.clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .bus_rx_in, .bus_tx_out,
        .eng_tx_bit, .eng_rx_bit, .eng_bit_tick, .eng_tx_allowed, .eng_rx_allowed, .eng_loopback,
        .eng_tx_pending, .eng_tx_from_priority(), .eng_tx_take, .eng_tx_done, .eng_rx_store,
        .eng_arb_lost(1'b0), .eng_error(1'b0), .eng_error_kind(5'h00), .eng_bus_off(1'b0),
        .eng_bus_idle, .eng_tec, .eng_rec, .irq_out);
    cmc_phy_model phy (.txd(bus_tx_out), .rxd(bus_rx_in), .other_dom);
    always #50 clock = ~clock;
    task give_verdict();
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // Request held until the rising edge that sees waitrequest low; answer taken there
    task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (k == 20) err_total++;
        rd_q = avs_readdata;
        rs_q = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task rd_chk(input logic [9:0] a, input logic [31:0] ex, input logic [1:0] er);
        bus(1'b0, a, 32'h0);
        `CHK("read data", ex, rd_q)
        `CHK("read response", er, rs_q)
    endtask
    task wr_chk(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
        bus(1'b1, a, d);
        `CHK("write response", er, rs_q)
    endtask
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (mode !== m && n < 300) begin
            @(posedge clock);
            n++;
        end
        `CHK("mode", m, mode)
    endtask
    task t_reset();
        `CHK("irq", 1'b0, irq_out)
        `CHK("tx pin", 1'b1, bus_tx_out)
        rd_chk(`CMC_OFF_SR, 32'h1, 2'h0);
        rd_chk(`CMC_OFF_SRR, 32'h0, 2'h0);
        rd_chk(10'h060, 32'h0, 2'h0);
        wr_chk(10'h104, 32'h0, 2'h3);
        wr_chk(`CMC_OFF_ECR, 32'h0, 2'h2);
    endtask
    task t_enable();
        other_dom <= 1'b1;
        wr_chk(`CMC_OFF_SRR, 32'h2, 2'h0);
        repeat (60) @(posedge clock);
        `CHK("mode with bus busy", 3'b000, mode)
        other_dom <= 1'b0;
        wait_mode(3'b110);
        `CHK("recessive wait", 1'b1, n >= 30 && n < 48)
        rd_chk(`CMC_OFF_SR, 32'h8, 2'h0);
        eng_tx_bit <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK("tx pin follows engine", 1'b0, bus_tx_out)
        eng_tx_bit <= 1'b1;
    endtask
    task t_config();
        eng_tec <= 8'h12;
        eng_rec <= 8'h34;
        wr_chk(`CMC_OFF_IER, 32'h12, 2'h0);
        wr_chk(`CMC_OFF_PRESCALER_REG, 32'h5, 2'h2);
        rd_chk(`CMC_OFF_ECR, 32'h3412, 2'h0);
        eng_tx_done <= 1'b1;
        @(posedge clock);
        eng_tx_done <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("irq on tx done", 1'b1, irq_out)
        wr_chk(`CMC_OFF_SRR, 32'h0, 2'h0);
        wait_mode(3'b000);
        rd_chk(`CMC_OFF_ISR, 32'h0, 2'h0);
        `CHK("irq after config entry", 1'b0, irq_out)
        rd_chk(`CMC_OFF_ECR, 32'h0, 2'h0);
        `CHK("tx pin in config", 1'b1, bus_tx_out)
        wr_chk(`CMC_OFF_PRESCALER_REG, 32'h5, 2'h0);
        rd_chk(`CMC_OFF_PRESCALER_REG, 32'h5, 2'h0);
        wr_chk(`CMC_OFF_PRESCALER_REG, 32'h0, 2'h0);
        eng_rx_store <= 1'b1;
        @(posedge clock);
        eng_rx_store <= 1'b0;
        bus(1'b0, `CMC_OFF_RXF_D2, 32'h0);
        rd_chk(`CMC_OFF_ISR, 32'h10, 2'h0);
        repeat (2) @(posedge clock);
        `CHK("irq in config", 1'b1, irq_out)
        wr_chk(`CMC_OFF_ICR, 32'h10, 2'h0);
        repeat (2) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq_out)
        wr_chk(`CMC_OFF_TXF_D2, 32'h0, 2'h0);
        wr_chk(`CMC_OFF_TXF_D2, 32'h0, 2'h0);
        `CHK("frames held back", 2'b01, {eng_tx_allowed, eng_tx_pending})
        rd_chk(`CMC_OFF_SR, 32'h801, 2'h0);
    endtask
    task t_sleep();
        wr_chk(`CMC_OFF_MSR, 32'h1, 2'h0);
        wr_chk(`CMC_OFF_IER, 32'h300, 2'h0);
        wr_chk(`CMC_OFF_SRR, 32'h2, 2'h0);
        wait_mode(3'b110);
        eng_bus_idle <= 1'b1;
        eng_tx_take <= 1'b1;
        repeat (2) @(posedge clock);
        eng_tx_take <= 1'b0;
        wait_mode(3'b010);
        rd_chk(`CMC_OFF_ISR, 32'h280, 2'h0);
        `CHK("irq on sleep", 1'b1, irq_out)
        wr_chk(`CMC_OFF_ICR, 32'hfff, 2'h0);
        wr_chk(`CMC_OFF_TXF_D2, 32'h0, 2'h0);
        wait_mode(3'b110);
        rd_chk(`CMC_OFF_ISR, 32'h100, 2'h0);
        eng_tx_take <= 1'b1;
        @(posedge clock);
        eng_tx_take <= 1'b0;
        wait_mode(3'b010);
        other_dom <= 1'b1;
        wait_mode(3'b110);
        other_dom <= 1'b0;
    endtask
    task t_loop();
        wr_chk(`CMC_OFF_SRR, 32'h0, 2'h0);
        wr_chk(`CMC_OFF_MSR, 32'h2, 2'h0);
        wr_chk(`CMC_OFF_SRR, 32'h2, 2'h0);
        wait_mode(3'b101);
        rd_chk(`CMC_OFF_SR, 32'h2, 2'h0);
        eng_tx_bit <= 1'b0;
        other_dom <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK("pin in loopback", 1'b1, bus_tx_out)
        `CHK("own bit looped", 1'b0, eng_rx_bit)
        eng_tx_bit <= 1'b1;
        other_dom <= 1'b0;
        wr_chk(`CMC_OFF_SRR, 32'h1, 2'h0);
        @(posedge clock);
        `CHK("mode after soft reset", 3'b000, mode)
        rd_chk(`CMC_OFF_SRR, 32'h0, 2'h0);
        rd_chk(`CMC_OFF_MSR, 32'h0, 2'h0);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_enable();
        t_config();
        t_sleep();
        t_loop();
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(`CMC_OFF_SR, 32'h1, 2'h0);
        give_verdict();
    end
endmodule
